// ===== logic/flc_pkg.sv
// Constants, code tables and carrier types of the 4B/5B line coder.
package flc_pkg;

  localparam logic [4:0] CODE_I     = 5'h1F;
  localparam logic [4:0] CODE_J     = 5'h18;
  localparam logic [4:0] CODE_K     = 5'h11;
  localparam logic [4:0] CODE_T     = 5'h0D;
  localparam logic [4:0] CODE_R     = 5'h07;
  localparam logic [4:0] CODE_H     = 5'h04;
  localparam logic [3:0] NIB_START  = 4'h5;
  localparam logic [3:0] NIB_IDLE   = 4'h0;
  localparam logic [3:0] NIB_BAD    = 4'hE;
  localparam int         SYM_BITS   = 5;
  localparam logic [2:0] SYM_LAST   = 3'h4;
  localparam int         LOCK_IDLES = 12;
  localparam int         LOCK_BITS  = LOCK_IDLES * SYM_BITS;
  localparam logic [1:0] STOP_IDLES = 2'h2;
  localparam int         LFSR_W     = 11;
  localparam int         LFSR_TAP_A = 10;
  localparam int         LFSR_TAP_B = 8;
  localparam logic [5:0] SEED_HI    = 6'h2B;
  localparam logic [LFSR_W-1:0] LFSR_RESET = 11'h7FF;

  // Data code-groups, indexed by the nibble they carry.
  localparam logic [15:0][4:0] ENC_TABLE = {
    5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E
  };

  typedef enum logic [2:0] {
    K_DATA, K_IDLE, K_J, K_K, K_T, K_R, K_HALT, K_BAD
  } flc_kind_e;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } flc_mii_tx_s;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } flc_mii_rx_s;

  typedef struct packed {
    logic pos;
    logic neg;
  } flc_mlt_s;

  typedef struct packed {
    flc_kind_e  kind;
    logic [3:0] nib;
  } flc_dec_s;

  function automatic logic [4:0] flc_encode(input logic [3:0] n);
    return ENC_TABLE[n];
  endfunction : flc_encode

  function automatic flc_dec_s flc_decode(input logic [4:0] s);
    flc_dec_s d;
    d.kind = K_BAD;
    d.nib  = NIB_IDLE;
    for (int i = 0; i < 16; i++) begin
      if (ENC_TABLE[i] == s) begin
        d.kind = K_DATA;
        d.nib  = 4'(i);
      end
    end
    unique case (s)
      CODE_I: d.kind = K_IDLE;
      CODE_J: begin
        d.kind = K_J;
        d.nib  = NIB_START;
      end
      CODE_K: begin
        d.kind = K_K;
        d.nib  = NIB_START;
      end
      CODE_T: d.kind = K_T;
      CODE_R: d.kind = K_R;
      CODE_H: d.kind = K_HALT;
      default: ;
    endcase
    return d;
  endfunction : flc_decode

endpackage : flc_pkg

// ===== logic/flc_lfsr.sv
// Eleven-bit scrambling sequence generator, closed loop or loaded from data.
`timescale 1ns/1ps
module flc_lfsr #(
  parameter int WIDTH = flc_pkg::LFSR_W,
  parameter int TAP_A = flc_pkg::LFSR_TAP_A,
  parameter int TAP_B = flc_pkg::LFSR_TAP_B
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             step_in,
  input  wire logic             open_in,
  input  wire logic             bit_in,
  input  wire logic             seed_load_in,
  input  wire logic [WIDTH-1:0] seed_in,
  output logic                  key_out
);

  typedef struct packed {
    logic [WIDTH-1:0] sr;
  } flc_lfsr_s;

  flc_lfsr_s st_reg;
  flc_lfsr_s st_next;

  if (TAP_A >= WIDTH || TAP_B >= WIDTH || TAP_A == TAP_B) begin : g_bad
    $error("flc_lfsr: taps must be distinct and inside the register");
  end

  assign key_out = st_reg.sr[TAP_A] ^ st_reg.sr[TAP_B];

  // Open mode shifts in the observed sequence so a receiver can catch up.
  always_comb begin
    st_next = st_reg;
    if (seed_load_in) begin
      st_next.sr = seed_in;
    end else if (step_in) begin
      st_next.sr = {st_reg.sr[WIDTH-2:0], open_in ? bit_in : key_out};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '{sr: WIDTH'(flc_pkg::LFSR_RESET)};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : flc_lfsr

// ===== logic/flc_line_coder.sv
// 100 Mb/s 4B/5B coder: encode, scramble, NRZI, MLT-3 and the receive path.
`timescale 1ns/1ps
// Summary of operation
// - Each transmit nibble after J/K without error becomes its fixed five-bit data code-group.
// - Code-group 00100 is the halt symbol, sent for errors, never data.
// - Unused codes and control codes inside data are invalid with error.
// - Frame start replaces the first two preamble nibbles with J then K.
// - After J/K every preamble and data nibble without error is sent encoded.
// - When transmit enable drops, T then R close the frame.
// - After T/R idle code-groups run until enable returns.
// - An eleven-bit closed-loop LFSR is XORed onto the serial stream.
// - The scrambler seed is SEED_HI above the five station address straps.
// - The scrambled stream always passes NRZI encoding, no bypass.
// - The NRZI stage also yields the MLT-3 value for loopback.
// - MLT-3 output is two streams whose one events alternate.
// - MLT-3 symbols drive the line; the plain NRZI bit is also emitted on nrzi_out.
// - Receive turns the scrambled MLT-3 stream into nibbles.
// - Received MLT-3 levels are decoded to binary NRZI.
// - Link pulses alone never assert signal detect.
// - Each start delimiter symbol is presented as nibble 0101.
// - Idle and both end symbols are presented as nibble 0000.
// - Descrambler locks only after twelve consecutive idle groups.
// - Symbol alignment is fixed when an idle group followed by J is seen.
// - Decoding stops on T/R or after two idle groups.
module flc_line_coder #(
  parameter int BIT_DIV = 1
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [4:0]           station_address_straps_in,
  input  wire flc_pkg::flc_mii_tx_s mii_tx_in,
  input  wire logic                 loopback_in,
  input  wire flc_pkg::flc_mlt_s    line_rx_in,
  output logic                      tx_ack_out,
  output flc_pkg::flc_mlt_s         line_tx_out,
  output logic                      nrzi_out,
  output flc_pkg::flc_mii_rx_s      mii_rx_out,
  output logic                      rx_stb_out,
  output logic                      signal_detect_out
);

  localparam int DIV_W = $clog2(BIT_DIV + 1);

  typedef enum logic [2:0] {
    TX_IDLE, TX_J, TX_K, TX_DATA, TX_T, TX_R
  } flc_tx_e;

  typedef enum logic [2:0] {
    RX_HUNT, RX_K, RX_DATA, RX_END, RX_BAD
  } flc_rx_e;

  typedef struct packed {
    logic [DIV_W-1:0]     div;
    logic                 bit_en;
    logic                 seeded;
    flc_tx_e              txs;
    logic [2:0]           tx_cnt;
    logic [4:0]           tx_sym;
    logic                 tx_ack;
    logic                 nrzi;
    logic [1:0]           mlt_ph;
    flc_pkg::flc_mlt_s    mlt;
    flc_pkg::flc_mlt_s    rx_prev;
    logic                 rx_nrzi;
    logic [9:0]           rx_win;
    logic                 locked;
    logic [5:0]           idle_run;
    flc_rx_e              rxs;
    logic [2:0]           rx_cnt;
    logic [1:0]           rx_idles;
    flc_pkg::flc_mii_rx_s rx;
    logic                 rx_stb;
  } flc_state_s;

  flc_state_s        st_reg;
  flc_state_s        st_next;
  logic              tx_key;
  logic              tx_scr;
  logic              tx_load;
  logic              rx_key;
  logic              rx_sd;
  logic              rx_ud;
  logic              rx_sym_done;
  logic [9:0]        rx_win_next;
  flc_pkg::flc_dec_s rx_dec;
  flc_pkg::flc_mlt_s rx_line;

  if (BIT_DIV < 1) begin : g_bad_div
    $error("flc_line_coder: BIT_DIV must be at least 1");
  end

  flc_lfsr u_tx_lfsr (
    .clk_in       (ref_clk_in),
    .rst_n_in     (rst_n_in),
    .step_in      (st_reg.bit_en && st_reg.seeded),
    .open_in      (1'b0),
    .bit_in       (1'b0),
    .seed_load_in (!st_reg.seeded),
    .seed_in      ({flc_pkg::SEED_HI, station_address_straps_in}),
    .key_out      (tx_key)
  );

  // Until locked the receive generator is loaded with the line bits that
  // an idle stream implies; once locked it runs on its own.
  flc_lfsr u_rx_lfsr (
    .clk_in       (ref_clk_in),
    .rst_n_in     (rst_n_in),
    .step_in      (st_reg.bit_en),
    .open_in      (!st_reg.locked),
    .bit_in       (~rx_sd),
    .seed_load_in (1'b0),
    .seed_in      ('0),
    .key_out      (rx_key)
  );

  assign tx_scr      = st_reg.tx_sym[4] ^ tx_key;
  assign tx_load     = st_reg.bit_en && st_reg.seeded
                       && st_reg.tx_cnt == flc_pkg::SYM_LAST;
  assign rx_line     = loopback_in ? st_reg.mlt : line_rx_in;
  assign rx_sd       = rx_line != st_reg.rx_prev;
  assign rx_ud       = rx_sd ^ rx_key;
  assign rx_win_next = {st_reg.rx_win[8:0], rx_ud};
  assign rx_dec      = flc_pkg::flc_decode(rx_win_next[4:0]);
  assign rx_sym_done = st_reg.bit_en && st_reg.rxs != RX_HUNT
                       && st_reg.rx_cnt == flc_pkg::SYM_LAST;

  always_comb begin
    st_next        = st_reg;
    st_next.tx_ack = 1'b0;
    st_next.rx_stb = 1'b0;
    st_next.seeded = 1'b1;
    if (st_reg.div == '0) begin
      st_next.div    = DIV_W'(BIT_DIV - 1);
      st_next.bit_en = 1'b1;
    end else begin
      st_next.div    = st_reg.div - 1'b1;
      st_next.bit_en = 1'b0;
    end
    // Transmit: shift out one code bit per bit time, MSB first.
    if (st_reg.bit_en && st_reg.seeded) begin
      st_next.tx_sym = {st_reg.tx_sym[3:0], 1'b0};
      st_next.tx_cnt = st_reg.tx_cnt + 3'h1;
      st_next.nrzi   = st_reg.nrzi ^ tx_scr;
      if (tx_scr) begin
        st_next.mlt_ph = st_reg.mlt_ph + 2'h1;
      end
      st_next.mlt.pos = st_next.mlt_ph == 2'h1;
      st_next.mlt.neg = st_next.mlt_ph == 2'h3;
    end
    if (tx_load) begin
      st_next.tx_cnt = 3'h0;
      unique case (st_reg.txs)
        TX_IDLE, TX_R: begin
          if (mii_tx_in.en) begin
            st_next.tx_sym = flc_pkg::CODE_J;
            st_next.txs    = TX_J;
            st_next.tx_ack = 1'b1;
          end else begin
            st_next.tx_sym = flc_pkg::CODE_I;
            st_next.txs    = TX_IDLE;
          end
        end
        TX_J: begin
          st_next.tx_sym = flc_pkg::CODE_K;
          st_next.txs    = TX_K;
          st_next.tx_ack = 1'b1;
        end
        TX_K, TX_DATA: begin
          if (mii_tx_in.en) begin
            st_next.tx_sym = mii_tx_in.er ? flc_pkg::CODE_H
                           : flc_pkg::flc_encode(mii_tx_in.d);
            st_next.txs    = TX_DATA;
            st_next.tx_ack = 1'b1;
          end else begin
            st_next.tx_sym = flc_pkg::CODE_T;
            st_next.txs    = TX_T;
          end
        end
        TX_T: begin
          st_next.tx_sym = flc_pkg::CODE_R;
          st_next.txs    = TX_R;
        end
      endcase
    end
    // Receive: level changes are NRZI transitions; descramble per bit.
    if (st_reg.bit_en) begin
      st_next.rx_prev = rx_line;
      st_next.rx_nrzi = st_reg.rx_nrzi ^ rx_sd;
      st_next.rx_win  = rx_win_next;
      st_next.rx_cnt  = st_reg.rx_cnt + 3'h1;
      if (!st_reg.locked) begin
        st_next.idle_run = rx_ud ? st_reg.idle_run + 6'h01 : 6'h00;
        if (rx_ud && st_reg.idle_run == 6'(flc_pkg::LOCK_BITS - 1)) begin
          st_next.locked = 1'b1;
        end
      end
      if (st_reg.locked && st_reg.rxs == RX_HUNT
          && rx_win_next == {flc_pkg::CODE_I, flc_pkg::CODE_J}) begin
        st_next.rx_cnt   = 3'h0;
        st_next.rxs      = RX_K;
        st_next.rx       = '{dv: 1'b1, er: 1'b0, d: flc_pkg::NIB_START};
        st_next.rx_stb   = 1'b1;
      end
    end
    if (rx_sym_done) begin
      st_next.rx_cnt = 3'h0;
      st_next.rx_stb = 1'b1;
      unique case (st_reg.rxs)
        RX_K: begin
          if (rx_dec.kind == flc_pkg::K_K) begin
            st_next.rx  = '{dv: 1'b1, er: 1'b0, d: flc_pkg::NIB_START};
            st_next.rxs = RX_DATA;
          end else begin
            st_next.rx       = '{dv: 1'b0, er: 1'b1, d: flc_pkg::NIB_BAD};
            st_next.rxs      = RX_BAD;
            st_next.rx_idles = 2'h0;
          end
        end
        RX_DATA: begin
          st_next.rx = '{dv: 1'b1, er: 1'b0, d: rx_dec.nib};
          if (rx_dec.kind == flc_pkg::K_DATA) begin
            st_next.rx_idles = 2'h0;
          end else if (rx_dec.kind == flc_pkg::K_T) begin
            st_next.rx.dv = 1'b0;
            st_next.rxs   = RX_END;
          end else if (rx_dec.kind == flc_pkg::K_IDLE
                       && st_reg.rx_idles == flc_pkg::STOP_IDLES - 2'h1) begin
            st_next.rx    = '{dv: 1'b0, er: 1'b0, d: flc_pkg::NIB_IDLE};
            st_next.rxs   = RX_HUNT;
          end else begin
            st_next.rx.er = 1'b1;
            if (rx_dec.kind == flc_pkg::K_IDLE) begin
              st_next.rx_idles = st_reg.rx_idles + 2'h1;
            end
          end
        end
        RX_END: begin
          st_next.rx  = '{dv: 1'b0, er: 1'b0, d: flc_pkg::NIB_IDLE};
          st_next.rxs = RX_HUNT;
        end
        RX_BAD: begin
          if (rx_dec.kind == flc_pkg::K_IDLE) begin
            st_next.rx_idles = st_reg.rx_idles + 2'h1;
          end else begin
            st_next.rx_idles = 2'h0;
          end
          if (st_next.rx_idles == flc_pkg::STOP_IDLES) begin
            st_next.rx  = '{dv: 1'b0, er: 1'b0, d: flc_pkg::NIB_IDLE};
            st_next.rxs = RX_HUNT;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg        <= '0;
      st_reg.txs    <= TX_IDLE;
      st_reg.rxs    <= RX_HUNT;
      st_reg.tx_sym <= flc_pkg::CODE_I;
      st_reg.tx_cnt <= 3'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tx_ack_out        = st_reg.tx_ack;
  assign line_tx_out       = st_reg.mlt;
  assign nrzi_out          = st_reg.nrzi;
  assign mii_rx_out        = st_reg.rx;
  assign rx_stb_out        = st_reg.rx_stb;
  assign signal_detect_out = st_reg.locked;

  sequence s_load_busy;
    tx_load && (st_reg.txs == TX_K || st_reg.txs == TX_DATA);
  endsequence

  sequence s_load_quiet;
    tx_load && (st_reg.txs == TX_IDLE || st_reg.txs == TX_R);
  endsequence

  property p_tx_start;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_load_quiet ##0 mii_tx_in.en
    |=> st_reg.tx_sym == flc_pkg::CODE_J && st_reg.txs == TX_J
        && st_reg.tx_ack;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("frame did not open with J");

  property p_tx_data;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_load_busy ##0 mii_tx_in.en && !mii_tx_in.er
    |=> st_reg.tx_sym == flc_pkg::flc_encode($past(mii_tx_in.d));
  endproperty
  a_tx_data: assert property (p_tx_data)
    else $error("nibble not mapped to its code-group");

  property p_tx_halt;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_load_busy ##0 mii_tx_in.en && mii_tx_in.er
    |=> st_reg.tx_sym == flc_pkg::CODE_H && st_reg.tx_ack;
  endproperty
  a_tx_halt: assert property (p_tx_halt)
    else $error("error nibble not sent as halt");

  property p_tx_end;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_load_busy ##0 !mii_tx_in.en |=> st_reg.tx_sym == flc_pkg::CODE_T;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("frame end did not send T");

  property p_tx_idle;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_load_quiet ##0 !mii_tx_in.en |=> st_reg.tx_sym == flc_pkg::CODE_I;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("idle not sent between frames");

  property p_nrzi;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    st_reg.bit_en && st_reg.seeded
    |=> (nrzi_out ^ $past(nrzi_out)) == $past(tx_scr);
  endproperty
  a_nrzi: assert property (p_nrzi)
    else $error("NRZI did not follow the scrambled bit");

  property p_mlt_split;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !(line_tx_out.pos && line_tx_out.neg)
    and ($rose(line_tx_out.pos) |-> $past(st_reg.mlt_ph) == 2'h0);
  endproperty
  a_mlt_split: assert property (p_mlt_split)
    else $error("MLT-3 streams out of step");

  property p_lock;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(signal_detect_out)
    |-> $past(st_reg.idle_run) == 6'(flc_pkg::LOCK_BITS - 1);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock without twelve idle groups");

  property p_rx_start;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rx_sym_done && st_reg.rxs == RX_K && rx_dec.kind == flc_pkg::K_K
    |=> mii_rx_out.dv && mii_rx_out.d == flc_pkg::NIB_START;
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("K not presented as start nibble");

  property p_rx_invalid;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rx_sym_done && st_reg.rxs == RX_DATA
    && rx_dec.kind inside {flc_pkg::K_BAD, flc_pkg::K_HALT,
                           flc_pkg::K_J, flc_pkg::K_K, flc_pkg::K_R}
    |=> mii_rx_out.er && rx_stb_out;
  endproperty
  a_rx_invalid: assert property (p_rx_invalid)
    else $error("invalid code in data without error");

endmodule : flc_line_coder

// ===== verification/flc_mac_model.sv
// Behavioural MAC that hands frames to the coder over the transmit side.
`timescale 1ns/1ps
module flc_mac_model (
  input  wire logic            clk_in,
  input  wire logic            ack_in,
  output flc_pkg::flc_mii_tx_s tx_out
);

  initial begin
    tx_out = '0;
  end

  // Each nibble stays on the bus until the acknowledge is sampled high or 20 clocks pass.
  task automatic send(input logic [3:0] nib[$], input int err_at,
                      output bit ok);
    int n;
    ok = 1'b1;
    @(posedge clk_in);
    #5;
    foreach (nib[i]) begin
      tx_out.en = 1'b1;
      tx_out.er = (i == err_at);
      tx_out.d  = nib[i];
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (ack_in !== 1'b1 && n < 20);
      if (n >= 20) ok = 1'b0;
      #5;
    end
    // Released data lines show the inverse rather than a stale nibble.
    tx_out.en = 1'b0;
    tx_out.er = 1'b0;
    tx_out.d  = ~tx_out.d;
  endtask : send

endmodule : flc_mac_model

// ===== verification/tb_top.sv
// Loopback testbench of the 4B/5B line coder with a scoreboard queue.
`timescale 1ns/1ps
module tb_top;
  logic                 ref_clk_in;
  logic                 rst_n_in;
  logic                 loopback_in;
  logic [4:0]           straps;
  flc_pkg::flc_mii_tx_s mii_tx;
  flc_pkg::flc_mii_rx_s mii_rx;
  flc_pkg::flc_mlt_s    line_rx;
  flc_pkg::flc_mlt_s    line_tx;
  flc_pkg::flc_mlt_s    prev_line;
  logic                 tx_ack;
  logic                 nrzi;
  logic                 prev_nrzi;
  logic                 rx_stb;
  logic                 sig_det;
  logic                 last_pos;
  logic [5:0]           exp_q[$];
  int                   errors;
  int                   checks_done;
  int                   cycles;
  int                   seed;

  flc_line_coder #(.BIT_DIV(1)) uut (
    .ref_clk_in                (ref_clk_in),
    .rst_n_in                  (rst_n_in),
    .station_address_straps_in (straps),
    .mii_tx_in                 (mii_tx),
    .loopback_in               (loopback_in),
    .line_rx_in                (line_rx),
    .tx_ack_out                (tx_ack),
    .line_tx_out               (line_tx),
    .nrzi_out                  (nrzi),
    .mii_rx_out                (mii_rx),
    .rx_stb_out                (rx_stb),
    .signal_detect_out         (sig_det)
  );

  flc_mac_model mac (
    .clk_in (ref_clk_in),
    .ack_in (tx_ack),
    .tx_out (mii_tx)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input logic [5:0] seen, input logic [5:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("counts: %0d checks, %0d mismatches", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // Ternary noise on the line input; ignored while loopback is selected.
  always @(posedge ref_clk_in) begin
    #5;
    case ($unsigned($random(seed)) % 3)
      0: line_rx = 2'b00;
      1: line_rx = 2'b10;
      default: line_rx = 2'b01;
    endcase
  end

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      $display("BAD %0t run did not finish in time", $time);
      summarize();
    end
  end

  always @(posedge ref_clk_in) begin
    if (rst_n_in && rx_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("BAD %0t nibble outside a frame: %h", $time, mii_rx);
      end else begin
        check(mii_rx, exp_q.pop_front(), "receive nibble");
      end
    end
  end

  // Line drive: halves exclusive, steps tied to NRZI toggles, 0 + 0 - order.
  always @(posedge ref_clk_in) begin
    if (rst_n_in) begin
      check({5'h0, line_tx.pos & line_tx.neg}, 6'h00, "both halves");
      check({5'h0, line_tx != prev_line}, {5'h0, nrzi != prev_nrzi},
            "line step vs nrzi");
      if (line_tx != prev_line) begin
        check({5'h0, prev_line == 2'b00}, {5'h0, line_tx != 2'b00},
              "mlt level step");
        if (line_tx != 2'b00) begin
          check({5'h0, line_tx.pos}, {5'h0, !last_pos}, "mlt polarity");
          last_pos = line_tx.pos;
        end
      end
    end else begin
      last_pos = 1'b0;
    end
    prev_line = line_tx;
    prev_nrzi = nrzi;
  end

  task automatic do_reset(input logic loop);
    @(posedge ref_clk_in);
    #5;
    rst_n_in    = 1'b0;
    loopback_in = loop;
    straps      = 5'($random(seed));
    repeat (12) @(posedge ref_clk_in);
    #5;
    rst_n_in = 1'b1;
  endtask : do_reset

  task automatic frame(input logic [3:0] data[$], input int err_at);
    logic [3:0] nibs[$];
    bit         ok;
    int         n;
    nibs = {4'h5, 4'h5};
    exp_q.push_back(6'h25);
    exp_q.push_back(6'h25);
    foreach (data[i]) begin
      nibs.push_back(data[i]);
      exp_q.push_back(i == err_at ? 6'h30 : {2'b10, data[i]});
    end
    exp_q.push_back(6'h00);
    exp_q.push_back(6'h00);
    mac.send(nibs, err_at < 0 ? -1 : err_at + 2, ok);
    check({5'h0, ok}, 6'h01, "nibble acknowledges");
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge ref_clk_in);
      n++;
    end
    check({5'h0, exp_q.size() == 0}, 6'h01, "frame delivered");
    exp_q.delete();
    repeat (30) @(posedge ref_clk_in);
    $display("test frame of %0d nibbles done", data.size());
  endtask : frame

  initial begin
    logic [3:0] data[$];
    int         n;
    rst_n_in    = 1'b0;
    loopback_in = 1'b0;
    straps      = 5'h00;
    line_rx     = '0;
    prev_line   = '0;
    prev_nrzi   = 1'b0;
    last_pos    = 1'b0;
    seed        = 64306;
    errors      = 0;
    checks_done = 0;
    cycles      = 0;
    for (int r = 0; r < 2; r++) begin
      do_reset(r != 0);
      if (r == 0) begin
        repeat (300) @(posedge ref_clk_in);
        check({5'h0, sig_det}, 6'h00, "detect on noise");
        $display("test noise without idles done");
        #5;
        loopback_in = 1'b1;
      end
      n = 0;
      while (sig_det !== 1'b1 && n < 1000) begin
        @(posedge ref_clk_in);
        n++;
      end
      check({5'h0, sig_det}, 6'h01, "lock on idles");
      check({5'h0, n >= 60}, 6'h01, "lock needs twelve idles");
      $display("test lock done after %0d cycles", n);
      data.delete();
      for (int i = 0; i < 16; i++) data.push_back(4'(i));
      frame(data, -1);
      frame(data, 7);
      for (int f = 0; f < 3; f++) begin
        data.delete();
        n = 1 + $unsigned($random(seed)) % 12;
        repeat (n) data.push_back(4'($random(seed)));
        frame(data, f == 1 ? n - 1 : -1);
      end
    end
    summarize();
  end

endmodule : tb_top
